// ### dmc_pkg.sv
package dmc_pkg;

    localparam int DATA_W    = 16;
    localparam int ADDR_W    = 16;
    localparam int NUM_WORDS = 10;
    localparam int IDX_W     = 4;
    localparam int EXC_W     = 8;

    // Word indices inside the store
    localparam logic [IDX_W-1:0] IDX_SF1  = 4'h0;
    localparam logic [IDX_W-1:0] IDX_SF2  = 4'h1;
    localparam logic [IDX_W-1:0] IDX_AUTO_ENABLE_LIMIT_RESET_WORD = 4'h2;
    localparam logic [IDX_W-1:0] IDX_ADR  = 4'h3;
    localparam logic [IDX_W-1:0] IDX_RATE = 4'h4;
    localparam logic [IDX_W-1:0] IDX_CONN = 4'h5;
    localparam logic [IDX_W-1:0] IDX_ERRH = 4'h6;
    localparam logic [IDX_W-1:0] IDX_TMO  = 4'h7;
    localparam logic [IDX_W-1:0] IDX_ADR2 = 4'h8;
    localparam logic [IDX_W-1:0] IDX_FORC = 4'h9;
    localparam logic [IDX_W-1:0] IDX_NONE = 4'hF;
    localparam logic [IDX_W-1:0] IDX_LAST = 4'h9;

    // Modbus register addresses
    localparam logic [ADDR_W-1:0] ADDR_SF1  = 16'h0382;
    localparam logic [ADDR_W-1:0] ADDR_SF2  = 16'h0384;
    localparam logic [ADDR_W-1:0] ADDR_AUTO_ENABLE_LIMIT_RESET_WORD = 16'h0388;
    localparam logic [ADDR_W-1:0] ADDR_ADR  = 16'h0400;
    localparam logic [ADDR_W-1:0] ADDR_RATE = 16'h0402;
    localparam logic [ADDR_W-1:0] ADDR_CONN = 16'h0404;
    localparam logic [ADDR_W-1:0] ADDR_ERRH = 16'h0406;
    localparam logic [ADDR_W-1:0] ADDR_TMO  = 16'h0408;
    localparam logic [ADDR_W-1:0] ADDR_ADR2 = 16'h040A;
    localparam logic [ADDR_W-1:0] ADDR_FORC = 16'h040C;

    // Per word, in index order: factory value, legal range, legal bits, stored bits
    localparam logic [DATA_W-1:0] WORD_DFLT [NUM_WORDS] = '{
        16'h0200, 16'h0000, 16'h0100, 16'h007F, 16'h0000,
        16'h0007, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [DATA_W-1:0] WORD_MIN [NUM_WORDS] = '{
        16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000,
        16'h0006, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [DATA_W-1:0] WORD_MAX [NUM_WORDS] = '{
        16'hFFC0, 16'h0004, 16'h0111, 16'h00F7, 16'hFFFF,
        16'h0009, 16'h0001, 16'h4E20, 16'h007F, 16'h07FF};
    localparam logic [DATA_W-1:0] WORD_LEGAL [NUM_WORDS] = '{
        16'hFFC0, 16'h0004, 16'h0111, 16'hFFFF, 16'hFFFF,
        16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
    localparam logic [DATA_W-1:0] WORD_STORE [NUM_WORDS] = '{
        16'h7FC0, 16'h0004, 16'h0111, 16'hFFFF, 16'hFFFF,
        16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
    // Words whose writes act at once; the rest wait for the next power-on
    localparam logic [NUM_WORDS-1:0] WORD_IMMEDIATE = 10'h2C3;

    // Field positions
    localparam int SF1_MOTOR_PHASE_BIT = 9;
    localparam int SF1_LIMIT_INHIBIT_BIT = 11;
    localparam int SF1_MAINS_PHASE_BIT = 12;
    localparam int SF1_ENC_OUT_BIT = 13;
    localparam int SF1_FREQ_UNIT_BIT = 14;
    localparam int SF2_UV_AUTO_BIT = 2;
    localparam int AUTO_ENABLE_LIMIT_RESET_WORD_Z_BIT = 8;
    localparam int ERRH_FAULT_BIT = 0;
    localparam int FORCE_INPUTS = 8;

    localparam logic [DATA_W-1:0] LIMIT_RESP_A = 16'h0001;
    localparam logic [DATA_W-1:0] LIMIT_RESP_B = 16'h0003;

    // Modbus exception answers
    localparam logic [EXC_W-1:0] EXC_NONE          = 8'h00;
    localparam logic [EXC_W-1:0] EXC_ILLEGAL_ADDR  = 8'h02;
    localparam logic [EXC_W-1:0] EXC_ILLEGAL_VALUE = 8'h03;

    // Timing
    localparam int CLK_HZ = 20000000;
    localparam int MS_PER_S = 1000;
    localparam int CYCLES_PER_MS_DFLT = CLK_HZ / MS_PER_S;

    typedef enum logic [1:0] {
        DMC_ST_LOAD    = 2'b00,
        DMC_ST_IDLE    = 2'b01,
        DMC_ST_RESTORE = 2'b11
    } dmc_state_e;

endpackage

// ### dmc_word_store.sv
`timescale 1ns/1ps
// Retained word store; contents survive resetn, which stands for a power cycle
module dmc_word_store #(
    parameter int W     = 16,
    parameter int DEPTH = 10,
    parameter int AW    = 4
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata
);

    logic [W-1:0] mem [DEPTH];
    logic [W-1:0] rdata_ff;

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (re) begin
            rdata_ff <= mem[raddr];
        end
    end

    assign rdata = rdata_ff;

endmodule // dmc_word_store

// ### dmc_config_bank.sv
`timescale 1ns/1ps
module dmc_config_bank #(
    parameter int CYCLES_PER_MS = dmc_pkg::CYCLES_PER_MS_DFLT
) (
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire logic                        req_valid,
    output logic                             req_ready,
    input  wire logic                        req_write,
    input  wire logic [dmc_pkg::ADDR_W-1:0]  req_addr,
    input  wire logic [dmc_pkg::DATA_W-1:0]  req_wdata,
    output logic                             rsp_valid,
    output logic      [dmc_pkg::DATA_W-1:0]  rsp_rdata,
    output logic      [dmc_pkg::EXC_W-1:0]   rsp_exception,
    input  wire logic                        restore_defaults,
    output logic                             load_busy,
    input  wire logic                        comm_activity,
    input  wire logic                        comm_error_in,
    input  wire logic                        fault_reset_in,
    input  wire logic                        undervoltage,
    input  wire logic                        negative_limit_input,
    input  wire logic                        positive_limit_input,
    input  wire logic [dmc_pkg::DATA_W-1:0]  limit_switch_response_setting,
    input  wire logic                        overtravel_retry,
    input  wire logic                        mains_phase_loss,
    input  wire logic                        encoder_output_fault,
    output logic                             limit_pulse_inhibit_en,
    output logic                             motor_phase_monitor_en,
    output logic                             mains_phase_monitor_en,
    output logic                             encoder_output_monitor_en,
    output logic                             freq_unit_centihz,
    output logic                             mains_phase_error,
    output logic                             encoder_output_error,
    output logic                             auto_fault_reset,
    output logic                             discard_missed_pulses,
    output logic                             undervoltage_fault,
    output logic                             overtravel_error,
    output logic                             conn_timeout,
    output logic                             comm_alert,
    output logic                             comm_fault,
    output logic      [dmc_pkg::DATA_W-1:0]  station_address,
    output logic      [dmc_pkg::DATA_W-1:0]  secondary_address,
    output logic      [dmc_pkg::DATA_W-1:0]  rate_select,
    output logic      [dmc_pkg::DATA_W-1:0]  connection_settings,
    output logic      [dmc_pkg::FORCE_INPUTS-1:0] force_permit
);
    import dmc_pkg::*;

    localparam int PW = $clog2(CYCLES_PER_MS + 1);
    localparam logic [PW-1:0] PRESC_LAST = PW'(CYCLES_PER_MS - 1);
    localparam logic [DATA_W-1:0] MS_SAT = 16'hFFFF;

    dmc_state_e             state_ff;
    dmc_state_e             nxt_state;
    logic [IDX_W-1:0]       seq_idx_ff;
    logic [IDX_W-1:0]       nxt_seq_idx;
    logic                   cap_vld_ff;
    logic [IDX_W-1:0]       cap_idx_ff;
    logic [DATA_W-1:0]      act_ff [NUM_WORDS];
    logic                   rsp_valid_ff;
    logic [EXC_W-1:0]       rsp_exc_ff;

    // Address decode and value check
    logic [IDX_W-1:0]       addr_idx;
    logic [IDX_W-1:0]       sel_idx;
    logic                   addr_ok;
    logic                   val_ok;
    logic                   take;
    logic                   wr_ok;
    logic [DATA_W-1:0]      wr_store;
    logic                   loading;
    logic                   restoring;
    logic                   mem_we;
    logic [IDX_W-1:0]       mem_waddr;
    logic [DATA_W-1:0]      mem_wdata;
    logic                   mem_re;
    logic [IDX_W-1:0]       mem_raddr;
    logic [DATA_W-1:0]      mem_rdata;

    assign addr_idx = (req_addr == ADDR_SF1)  ? IDX_SF1  :
                      (req_addr == ADDR_SF2)  ? IDX_SF2  :
                      (req_addr == ADDR_AUTO_ENABLE_LIMIT_RESET_WORD) ? IDX_AUTO_ENABLE_LIMIT_RESET_WORD :
                      (req_addr == ADDR_ADR)  ? IDX_ADR  :
                      (req_addr == ADDR_RATE) ? IDX_RATE :
                      (req_addr == ADDR_CONN) ? IDX_CONN :
                      (req_addr == ADDR_ERRH) ? IDX_ERRH :
                      (req_addr == ADDR_TMO)  ? IDX_TMO  :
                      (req_addr == ADDR_ADR2) ? IDX_ADR2 :
                      (req_addr == ADDR_FORC) ? IDX_FORC : IDX_NONE;
    assign addr_ok  = (addr_idx != IDX_NONE);
    assign sel_idx  = addr_ok ? addr_idx : IDX_SF1;
    // Range check covers every word; the rate word's range spans the full 16 bits
    assign val_ok   = (req_wdata >= WORD_MIN[sel_idx]) &&
                      (req_wdata <= WORD_MAX[sel_idx]) &&
                      ((req_wdata & ~WORD_LEGAL[sel_idx]) == '0);
    // Reserved top bit of word 0 is dropped even if a writer sets it
    assign wr_store = req_wdata & WORD_STORE[sel_idx];

    assign loading   = (state_ff == DMC_ST_LOAD);
    assign restoring = (state_ff == DMC_ST_RESTORE);
    // A restore request takes the slot ahead of any fieldbus access
    assign req_ready = (state_ff == DMC_ST_IDLE) && !restore_defaults;
    assign take      = req_valid && req_ready;
    assign wr_ok     = take && req_write && addr_ok && val_ok;
    assign load_busy = !(state_ff == DMC_ST_IDLE);

    assign mem_we    = wr_ok || restoring;
    assign mem_waddr = restoring ? seq_idx_ff : sel_idx;
    assign mem_wdata = restoring ? WORD_DFLT[seq_idx_ff] : wr_store;
    assign mem_re    = (take && !req_write && addr_ok) || loading;
    assign mem_raddr = loading ? seq_idx_ff : sel_idx;

    dmc_word_store #(
        .W     (DATA_W),
        .DEPTH (NUM_WORDS),
        .AW    (IDX_W)
    ) u_store (
        .clk   (clk),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .re    (mem_re),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // Sequencer: load retained words at power-on, or write factory values
    always_comb begin
        nxt_state   = state_ff;
        nxt_seq_idx = seq_idx_ff;
        case (state_ff)
            DMC_ST_LOAD: begin
                nxt_seq_idx = seq_idx_ff + 4'h1;
                if (seq_idx_ff == IDX_LAST) begin
                    nxt_state   = DMC_ST_IDLE;
                    nxt_seq_idx = '0;
                end
            end
            DMC_ST_IDLE: begin
                if (restore_defaults) begin
                    nxt_state   = DMC_ST_RESTORE;
                    nxt_seq_idx = '0;
                end
            end
            DMC_ST_RESTORE: begin
                nxt_seq_idx = seq_idx_ff + 4'h1;
                if (seq_idx_ff == IDX_LAST) begin
                    nxt_state   = DMC_ST_IDLE;
                    nxt_seq_idx = '0;
                end
            end
            default: begin
                nxt_state   = DMC_ST_IDLE;
                nxt_seq_idx = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_ff   <= DMC_ST_LOAD;
            seq_idx_ff <= '0;
            cap_vld_ff <= 1'b0;
            cap_idx_ff <= '0;
        end else begin
            state_ff   <= nxt_state;
            seq_idx_ff <= nxt_seq_idx;
            cap_vld_ff <= loading;
            cap_idx_ff <= seq_idx_ff;
        end
    end

    // Live copies: held words change only at load or restore, the others also on write
    for (genvar i = 0; i < NUM_WORDS; i++) begin : g_active
        localparam logic [IDX_W-1:0] MY_IDX = IDX_W'(i);
        always_ff @(posedge clk) begin
            if (!resetn) begin
                act_ff[i] <= WORD_DFLT[i];
            end else if (restoring && seq_idx_ff == MY_IDX) begin
                act_ff[i] <= WORD_DFLT[i];
            // Write wins over the last load capture, which can share its edge
            end else if (WORD_IMMEDIATE[i] && wr_ok && sel_idx == MY_IDX) begin
                act_ff[i] <= wr_store;
            end else if (cap_vld_ff && cap_idx_ff == MY_IDX) begin
                act_ff[i] <= mem_rdata;
            end
        end
    end

    // Answer one cycle after the request is taken
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rsp_valid_ff <= 1'b0;
            rsp_exc_ff   <= EXC_NONE;
        end else begin
            rsp_valid_ff <= take;
            if (take) begin
                if (!addr_ok) begin
                    rsp_exc_ff <= EXC_ILLEGAL_ADDR;
                end else if (req_write && !val_ok) begin
                    rsp_exc_ff <= EXC_ILLEGAL_VALUE;
                end else begin
                    rsp_exc_ff <= EXC_NONE;
                end
            end
        end
    end

    assign rsp_valid     = rsp_valid_ff;
    assign rsp_exception = rsp_exc_ff;
    assign rsp_rdata     = mem_rdata;

    // Configuration fields
    logic [DATA_W-1:0] sf1;
    logic [DATA_W-1:0] sf2;
    logic [DATA_W-1:0] tmo_ms;

    assign sf1    = act_ff[IDX_SF1];
    assign sf2    = act_ff[IDX_SF2];
    assign tmo_ms = act_ff[IDX_TMO];

    assign limit_pulse_inhibit_en    = !sf1[SF1_LIMIT_INHIBIT_BIT];
    assign motor_phase_monitor_en    = sf1[SF1_MOTOR_PHASE_BIT];
    assign mains_phase_monitor_en    = !sf1[SF1_MAINS_PHASE_BIT];
    assign encoder_output_monitor_en = !sf1[SF1_ENC_OUT_BIT];
    assign freq_unit_centihz         = sf1[SF1_FREQ_UNIT_BIT];
    assign station_address           = act_ff[IDX_ADR];
    assign secondary_address         = act_ff[IDX_ADR2];
    assign rate_select               = act_ff[IDX_RATE];
    assign connection_settings       = act_ff[IDX_CONN];
    // Permission only; forced values come from a separate diagnostic word
    assign force_permit = act_ff[IDX_FORC][FORCE_INPUTS-1:0];

    // Fault handling
    logic uv_prev_ff;
    logic uv_cleared;
    logic any_fault_reset;
    logic limit_hit;
    logic limit_trip_ff;
    logic resp_discards;
    logic mains_err_ff;
    logic enc_err_ff;
    logic auto_reset_ff;
    logic discard_ff;
    logic uv_fault_ff;
    logic overtravel_ff;

    assign uv_cleared      = uv_prev_ff && !undervoltage;
    assign any_fault_reset = fault_reset_in || (uv_cleared && sf2[SF2_UV_AUTO_BIT]);
    assign limit_hit       = negative_limit_input || positive_limit_input;
    assign resp_discards   = (limit_switch_response_setting == LIMIT_RESP_A) ||
                             (limit_switch_response_setting == LIMIT_RESP_B);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            uv_prev_ff    <= 1'b0;
            limit_trip_ff <= 1'b0;
            mains_err_ff  <= 1'b0;
            enc_err_ff    <= 1'b0;
            auto_reset_ff <= 1'b0;
            discard_ff    <= 1'b0;
            uv_fault_ff   <= 1'b0;
            overtravel_ff <= 1'b0;
        end else begin
            uv_prev_ff    <= undervoltage;
            mains_err_ff  <= mains_phase_loss && mains_phase_monitor_en;
            enc_err_ff    <= encoder_output_fault && encoder_output_monitor_en;
            auto_reset_ff <= uv_cleared && sf2[SF2_UV_AUTO_BIT];
            discard_ff    <= any_fault_reset && limit_trip_ff && resp_discards;
            // Set wins over the clear on each sticky flag
            limit_trip_ff <= limit_hit || (limit_trip_ff && !any_fault_reset);
            uv_fault_ff   <= (undervoltage && !uv_prev_ff) ||
                             (uv_fault_ff && !any_fault_reset);
            overtravel_ff <= (overtravel_retry && act_ff[IDX_AUTO_ENABLE_LIMIT_RESET_WORD][AUTO_ENABLE_LIMIT_RESET_WORD_Z_BIT]) ||
                             (overtravel_ff && !any_fault_reset);
        end
    end

    assign mains_phase_error     = mains_err_ff;
    assign encoder_output_error  = enc_err_ff;
    assign auto_fault_reset      = auto_reset_ff;
    assign discard_missed_pulses = discard_ff;
    assign undervoltage_fault    = uv_fault_ff;
    assign overtravel_error      = overtravel_ff;

    // Connection monitor, millisecond resolution
    logic [PW-1:0]     presc_ff;
    logic [DATA_W-1:0] ms_cnt_ff;
    logic              mon_on;
    logic              activity;
    logic              timeout_hit;
    logic              timeout_ff;
    logic              comm_event;
    logic              alert_ff;
    logic              fault_ff;

    assign mon_on      = (tmo_ms != '0);
    assign activity    = take || comm_activity;
    assign timeout_hit = mon_on && !activity && (ms_cnt_ff >= tmo_ms);
    assign comm_event  = comm_error_in || (timeout_hit && !timeout_ff);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            presc_ff  <= '0;
            ms_cnt_ff <= '0;
        end else if (!mon_on || activity) begin
            presc_ff  <= '0;
            ms_cnt_ff <= '0;
        end else if (presc_ff == PRESC_LAST) begin
            presc_ff  <= '0;
            if (ms_cnt_ff != MS_SAT) begin
                ms_cnt_ff <= ms_cnt_ff + 16'h0001;
            end
        end else begin
            presc_ff <= presc_ff + PW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            timeout_ff <= 1'b0;
            alert_ff   <= 1'b0;
            fault_ff   <= 1'b0;
        end else begin
            timeout_ff <= timeout_hit || (timeout_ff && !activity && mon_on);
            alert_ff   <= comm_event && !act_ff[IDX_ERRH][ERRH_FAULT_BIT];
            fault_ff   <= comm_event && act_ff[IDX_ERRH][ERRH_FAULT_BIT];
        end
    end

    assign conn_timeout = timeout_ff;
    assign comm_alert   = alert_ff;
    assign comm_fault   = fault_ff;

endmodule // dmc_config_bank

// ### dmc_config_bank_chk.sv
`timescale 1ns/1ps
module dmc_config_bank_chk (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        req_write,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic        rsp_valid,
    input wire logic        limit_pulse_inhibit_en,
    input wire logic        mains_phase_loss,
    input wire logic        mains_phase_monitor_en,
    input wire logic        mains_phase_error,
    input wire logic        undervoltage,
    input wire logic        undervoltage_fault,
    input wire logic        auto_fault_reset,
    input wire logic        overtravel_retry,
    input wire logic        overtravel_error,
    input wire logic        comm_activity,
    input wire logic        conn_timeout,
    input wire logic [15:0] station_address
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire wr_take = req_valid && req_ready && req_write;
    wire mains_cause = mains_phase_loss && mains_phase_monitor_en;
    property p_answer; req_valid && req_ready |=> rsp_valid; endproperty
    a_answer: assert property (p_answer) else $error("request got no answer");
    property p_inhibit; wr_take && req_addr == 16'h0382 && req_wdata[5:0] == 6'h00
        |=> limit_pulse_inhibit_en != $past(req_wdata[11]); endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit not inverse of bit");
    property p_mains; mains_phase_error |-> $past(mains_cause); endproperty
    a_mains: assert property (p_mains) else $error("mains error without cause");
    property p_uv_set; $rose(undervoltage_fault) |-> $past(undervoltage); endproperty
    a_uv_set: assert property (p_uv_set) else $error("undervoltage fault unprompted");
    property p_auto; auto_fault_reset |-> $past(undervoltage, 2) && !$past(undervoltage); endproperty
    a_auto: assert property (p_auto) else $error("auto reset not after fall");
    property p_otv; $rose(overtravel_error) |-> $past(overtravel_retry); endproperty
    a_otv: assert property (p_otv) else $error("overtravel error unprompted");
    property p_tmo; comm_activity |=> !conn_timeout; endproperty
    a_tmo: assert property (p_tmo) else $error("timeout survived activity");
    property p_defer; wr_take && req_addr == 16'h0400 |=> $stable(station_address); endproperty
    a_defer: assert property (p_defer) else $error("station address acted early");
endmodule // dmc_config_bank_chk

// ### dmc_master_model.sv
`timescale 1ns/1ps
module dmc_master_model (
    input  wire logic        clk,
    input  wire logic        req_ready,
    input  wire logic        rsp_valid,
    input  wire logic [15:0] rsp_rdata,
    input  wire logic [7:0]  rsp_exception,
    output logic             req_valid = 1'b0,
    output logic             req_write = 1'b0,
    output logic      [15:0] req_addr = 16'h0000,
    output logic      [15:0] req_wdata = 16'h0000
);
    // Entered at a falling edge; request held until taken
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] rd, output logic [7:0] ex, output bit lost);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = (a == 16'h0382) ? (d & 16'h7fff) : d;
        while (!req_ready && n < 40) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        rd = rsp_rdata;
        ex = rsp_exception;
        lost = (n >= 40) || !rsp_valid;
        req_valid = 1'b0;
        // Released lines show junk, not the last word
        req_addr = ~a;
        req_wdata = ~d;
        @(negedge clk);
    endtask
    // Forcing values go to a diagnostics word elsewhere, never here
endmodule // dmc_master_model

// ### dmc_config_bank_tb.sv
`timescale 1ns/1ps
module dmc_config_bank_tb;
    logic clk = 1'b0, resetn = 1'b0, restore_defaults = 1'b0, comm_activity = 1'b0;
    logic comm_error_in = 1'b0, fault_reset_in = 1'b0, undervoltage = 1'b0;
    logic negative_limit_input = 1'b0, positive_limit_input = 1'b0, overtravel_retry = 1'b0;
    logic mains_phase_loss = 1'b0, encoder_output_fault = 1'b0;
    logic [15:0] limit_switch_response_setting = 16'h0000;
    logic req_valid, req_ready, req_write, rsp_valid, load_busy, limit_pulse_inhibit_en;
    logic motor_phase_monitor_en, mains_phase_monitor_en, encoder_output_monitor_en;
    logic freq_unit_centihz, mains_phase_error, encoder_output_error, auto_fault_reset;
    logic discard_missed_pulses, undervoltage_fault, overtravel_error, conn_timeout;
    logic comm_alert, comm_fault;
    logic [15:0] req_addr, req_wdata, rsp_rdata, station_address, secondary_address;
    logic [15:0] rate_select, connection_settings;
    logic [7:0]  rsp_exception, force_permit;
    int          n_mismatch = 0;
    int          n_compared = 0;
    wire  [4:0]  sf1_out = {limit_pulse_inhibit_en, motor_phase_monitor_en,
                            mains_phase_monitor_en, encoder_output_monitor_en, freq_unit_centihz};
    localparam logic [31:0] FT [10] = '{32'h0382_0200, 32'h0384_0000, 32'h0388_0100,
        32'h0400_007f, 32'h0402_0000, 32'h0404_0007, 32'h0406_0000, 32'h0408_0000,
        32'h040a_0000, 32'h040c_0000};
    localparam logic [47:0] RT [10] = '{48'h0400_0000_0003, 48'h0400_00f8_0003,
        48'h0400_00f7_0000, 48'h0404_0005_0003, 48'h0404_000a_0003, 48'h0404_0009_0000,
        48'h040a_0080_0003, 48'h0388_0112_0003, 48'h0388_0111_0000, 48'h0408_4e21_0003};

    always #25 clk = ~clk;
    dmc_config_bank #(.CYCLES_PER_MS(4)) i_dut (.*);
    dmc_master_model i_mst (.*);

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic die();
        n_mismatch++;
        tally_and_finish();
    endtask
    // Power cycle, or restore factory values, then wait for the load
    task automatic up(input bit pwr);
        int n;
        n = 0;
        if (pwr) begin
            resetn = 1'b0;
            repeat (16) @(negedge clk);
            resetn = 1'b1;
        end else begin
            restore_defaults = 1'b1;
            @(negedge clk);
            restore_defaults = 1'b0;
        end
        repeat (2) @(negedge clk);
        chk({15'h0000, load_busy}, 16'h0001);
        while (!req_ready && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (n >= 40) die();
    endtask
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                       input logic [7:0] ee, input logic [15:0] er);
        logic [15:0] rd;
        logic [7:0] ex;
        bit lost;
        i_mst.xfer(w, a, d, rd, ex, lost);
        if (lost) die();
        chk({8'h00, ex}, {8'h00, ee});
        if (!w && ee == 8'h00) chk(rd, er);
    endtask

    initial begin
        up(1'b1);
        up(1'b0);
        up(1'b1);
        foreach (FT[i]) acc(1'b0, FT[i][31:16], '0, 8'h00, FT[i][15:0]);
        chk({station_address[7:0], connection_settings[7:0]}, 16'h7f07);
        chk({11'h000, sf1_out}, 16'h001e);
        $display("factory test done");
        foreach (RT[i]) acc(1'b1, RT[i][47:32], RT[i][31:16], RT[i][7:0], '0);
        acc(1'b0, 16'h0386, '0, 8'h02, '0);
        acc(1'b0, 16'h0400, '0, 8'h00, 16'h00f7);
        chk(station_address, 16'h007f);
        acc(1'b1, 16'h0402, 16'h0005, 8'h00, '0);
        acc(1'b1, 16'h040a, 16'h007f, 8'h00, '0);
        chk({rate_select[7:0], secondary_address[7:0]}, 16'h0000);
        $display("range test done");
        acc(1'b1, 16'h0382, 16'h7800, 8'h00, '0);
        chk({11'h000, sf1_out}, 16'h0001);
        mains_phase_loss = 1'b1;
        encoder_output_fault = 1'b1;
        repeat (2) @(negedge clk);
        chk({14'h0000, mains_phase_error, encoder_output_error}, 16'h0000);
        acc(1'b1, 16'h0382, 16'h0200, 8'h00, '0);
        chk({14'h0000, mains_phase_error, encoder_output_error}, 16'h0003);
        mains_phase_loss = 1'b0;
        encoder_output_fault = 1'b0;
        acc(1'b1, 16'h040c, 16'h07a5, 8'h00, '0);
        chk({8'h00, force_permit}, 16'h00a5);
        $display("function word test done");
        for (int i = 0; i < 2; i++) begin
            acc(1'b1, 16'h0406, 16'(i), 8'h00, '0);
            comm_error_in = 1'b1;
            @(negedge clk);
            comm_error_in = 1'b0;
            chk({14'h0000, comm_alert, comm_fault}, 16'h0002 >> i);
        end
        acc(1'b1, 16'h0408, 16'h0001, 8'h00, '0);
        repeat (8) @(negedge clk);
        chk({15'h0000, conn_timeout}, 16'h0001);
        comm_activity = 1'b1;
        @(negedge clk);
        comm_activity = 1'b0;
        chk({15'h0000, conn_timeout}, 16'h0000);
        $display("comm test done");
        acc(1'b1, 16'h0384, 16'h0004, 8'h00, '0);
        undervoltage = 1'b1;
        repeat (2) @(negedge clk);
        chk({15'h0000, undervoltage_fault}, 16'h0001);
        undervoltage = 1'b0;
        @(negedge clk);
        chk({15'h0000, auto_fault_reset}, 16'h0001);
        @(negedge clk);
        chk({15'h0000, undervoltage_fault}, 16'h0000);
        for (int j = 1; j < 4; j += 2) begin
            limit_switch_response_setting = 16'(j);
            negative_limit_input = 1'b1;
            overtravel_retry = 1'b1;
            @(negedge clk);
            overtravel_retry = 1'b0;
            negative_limit_input = 1'b0;
            fault_reset_in = 1'b1;
            chk({15'h0000, overtravel_error}, 16'h0001);
            @(negedge clk);
            fault_reset_in = 1'b0;
            chk({15'h0000, discard_missed_pulses}, 16'h0001);
            @(negedge clk);
            chk({15'h0000, overtravel_error}, 16'h0000);
        end
        $display("fault test done");
        up(1'b1);
        chk({station_address[7:0], connection_settings[7:0]}, 16'hf709);
        chk({rate_select[7:0], secondary_address[7:0]}, 16'h057f);
        $display("persistence test done");
        tally_and_finish();
    end
endmodule // dmc_config_bank_tb

bind dmc_config_bank dmc_config_bank_chk i_chk (.*);
